// [rtl/crm_top.sv]
// Clock reset mode control: watchdog, periodic timer, self clock, standby
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module crm_top
    import crm_pkg::*;
#(
    parameter int WDT_BASE = WDT_BASE_EXP, // Watchdog period exponent
    parameter int PIT_BASE = PIT_BASE_EXP  // Periodic period exponent
)(
    input wire logic CORE_CLK, // 10 MHz core clock
    input wire logic ARST_N, // Asynchronous reset
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // Write address
    input wire logic [2:0] S_AXI_AWPROT, // Unused protection
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Byte enables
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // Read address
    input wire logic [2:0] S_AXI_ARPROT, // Unused protection
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read valid
    input wire logic S_AXI_RREADY, // Read ready
    input wire logic STANDBY_REQ, // Core standby request level
    input wire logic CORE_WAKE, // Other wake interrupt from core
    input wire logic PSEUDO_STOP, // Device in pseudo-stop
    input wire logic OSC_FAIL, // Clock monitor fail, async
    input wire logic OSC_OK, // Quality checker oscillator good, async
    output logic SYS_RESET, // System reset pulse
    output logic [1:0] RESET_CAUSE, // Last internal reset cause
    output logic PIT_IRQ, // Periodic interrupt
    output logic SCM_IRQ, // Self clock interrupt
    output logic SELF_CLOCK_MODE, // Clocks from VCO minimum
    output logic PLL_SELECT, // System clock from PLL
    output logic PLL_ENABLE, // PLL powered
    output logic VOLTAGE_REGULATOR_ENABLE, // Regulator at full power
    output logic QC_START, // Start clock quality check pulse
    output logic CORE_CLK_EN, // Core clock gate
    output logic SYS_CLK_EN, // System clock gate
    output logic OSC_REDUCED, // Reduced oscillator amplitude
    output logic STANDBY_ACK // Standby active
);

    function automatic logic [CNT_W-1:0] period_of(input logic [2:0] rate,
                                                   input int base);
        period_of = {{(CNT_W-1){1'b0}}, 1'b1} << (5'(base) + {2'b00, rate});
    endfunction

    // Bus state
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    // Core state
    crm_ctrl_type ctrl, next_ctrl;
    logic [2:0] pit_rate, next_pit_rate, wdt_rate, next_wdt_rate;
    logic wdt_win, next_wdt_win, wdt_armed, next_wdt_armed;
    logic [CNT_W-1:0] wdt_cnt, next_wdt_cnt, pit_cnt, next_pit_cnt;
    logic pif, next_pif, self_clock_interrupt_flag, next_self_clock_interrupt_flag, self_clock_mode, next_scm;
    logic sys_reset, next_sys_reset, qc_start, next_qc_start;
    crm_cause_type cause, next_cause;
    crm_sb_type sb, next_sb;
    // Registered clock controls
    logic pll_en, next_pll_en, voltage_regulator_en, next_voltage_regulator_en;
    logic core_en, next_core_en, sys_en, next_sys_en;
    logic osc_red, next_osc_red;
    // Synchronisers
    logic fail_meta, fail_sync, fail_prev, ok_meta, ok_sync;

    logic wr_fire, rd_fire, wr_mapped, rd_mapped, svc_wr;
    logic [31:0] wmask, ctrl_merged;
    logic [CNT_W-1:0] wdt_period, pit_period, wdt_window;
    logic wdt_run, pit_run, wdt_timeout, key_bad, early, pit_tick;
    logic fail_event, cm_reset, scm_entry, scm_exit, wake, any_reset;
    logic [31:0] status_word;

    assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !bvalid;
    assign rd_fire = S_AXI_ARVALID && !rvalid;
    assign S_AXI_AWREADY = wr_fire;
    assign S_AXI_WREADY = wr_fire;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RRESP = rresp;
    assign S_AXI_RDATA = rdata;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == CTRL_ADDR) || (a == PIT_CTRL_ADDR)
            || (a == WDT_CTRL_ADDR) || (a == WDT_SVC_ADDR)
            || (a == STATUS_ADDR);
    endfunction

    assign wr_mapped = is_mapped(S_AXI_AWADDR);
    assign rd_mapped = is_mapped(S_AXI_ARADDR);
    assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                    {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
    assign ctrl_merged = ({19'h0, ctrl} & ~wmask) | (S_AXI_WDATA & wmask);
    assign svc_wr = wr_fire && S_AXI_AWADDR == WDT_SVC_ADDR
        && S_AXI_WSTRB[0];

    assign status_word = {26'h0, cause, (sb == SB_ACTIVE), self_clock_mode, self_clock_interrupt_flag, pif};

    // Watchdog: rate zero stops, standby/pseudo-stop gating
    assign wdt_period = period_of(wdt_rate, WDT_BASE);
    assign wdt_window = wdt_period - (wdt_period >> 2);
    assign wdt_run = (wdt_rate != 3'h0)
        && !(sb == SB_ACTIVE && ctrl.standby_watchdog_off)
        && !(PSEUDO_STOP && !ctrl.watchdog_pseudo_stop_enable);
    assign wdt_timeout = wdt_run && wdt_cnt == wdt_period - 1'b1;
    assign key_bad = svc_wr && S_AXI_WDATA[7:0] != SVC_KEY_ARM
        && S_AXI_WDATA[7:0] != SVC_KEY_FIRE;
    // Early service in windowed mode; software must wait
    assign early = svc_wr && !key_bad && wdt_rate != 3'h0 && wdt_win
        && wdt_cnt < wdt_window;

    // Periodic timer
    assign pit_period = period_of(pit_rate, PIT_BASE);
    assign pit_run = (pit_rate != 3'h0)
        && !(sb == SB_ACTIVE && ctrl.standby_periodic_timer_off)
        && !(PSEUDO_STOP && !ctrl.periodic_pseudo_stop_enable);
    assign pit_tick = pit_run && pit_cnt == pit_period - 1'b1;

    // Clock monitor fail handling
    assign fail_event = fail_sync && !fail_prev && ctrl.clock_monitor_enable;
    assign cm_reset = fail_event && !ctrl.self_clock_enable;
    assign scm_entry = fail_event && ctrl.self_clock_enable && !self_clock_mode;
    assign scm_exit = self_clock_mode && ok_sync;
    assign any_reset = wdt_timeout || key_bad || early || cm_reset;

    assign PIT_IRQ = pif && ctrl.periodic_interrupt_enable;
    assign SCM_IRQ = self_clock_interrupt_flag && ctrl.self_clock_interrupt_enable;
    // Wake only on enabled interrupts; masked self clock flag stays asleep
    assign wake = PIT_IRQ || SCM_IRQ || CORE_WAKE;

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
            fail_prev <= 1'b0;
            ok_meta <= 1'b0;
            ok_sync <= 1'b0;
        end
        else
        begin
            fail_meta <= OSC_FAIL;
            fail_sync <= fail_meta;
            fail_prev <= fail_sync;
            ok_meta <= OSC_OK;
            ok_sync <= ok_meta;
        end
    end

    // Bus slave next values
    always_comb
    begin
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (bvalid && S_AXI_BREADY)
            next_bvalid = 1'b0;
        if (wr_fire)
        begin
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && S_AXI_RREADY)
            next_rvalid = 1'b0;
        if (rd_fire)
        begin
            next_rvalid = 1'b1;
            next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
            unique case (S_AXI_ARADDR)
                CTRL_ADDR: next_rdata = {19'h0, ctrl};
                PIT_CTRL_ADDR: next_rdata = {29'h0, pit_rate};
                WDT_CTRL_ADDR: next_rdata = {24'h0, wdt_win, 4'h0, wdt_rate};
                STATUS_ADDR: next_rdata = status_word;
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0;
        end
        else
        begin
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // Core state next values
    always_comb
    begin
        next_ctrl = ctrl;
        next_pit_rate = pit_rate;
        next_wdt_rate = wdt_rate;
        next_wdt_win = wdt_win;
        next_wdt_armed = wdt_armed;
        next_wdt_cnt = wdt_run ? wdt_cnt + 1'b1 : wdt_cnt;
        next_pit_cnt = pit_run ? pit_cnt + 1'b1 : pit_cnt;
        next_pif = pif;
        next_self_clock_interrupt_flag = self_clock_interrupt_flag;
        next_scm = self_clock_mode;
        next_sys_reset = 1'b0;
        next_qc_start = 1'b0;
        next_cause = cause;
        next_sb = sb;
        if (wr_fire && S_AXI_AWADDR == CTRL_ADDR)
            next_ctrl = crm_ctrl_type'(ctrl_merged[12:0]);
        if (wr_fire && S_AXI_AWADDR == PIT_CTRL_ADDR)
        begin
            if (S_AXI_WSTRB[0])
                next_pit_rate = S_AXI_WDATA[2:0];
            next_pit_cnt = '0;
        end
        else if (pit_tick)
            next_pit_cnt = '0;
        if (wr_fire && S_AXI_AWADDR == WDT_CTRL_ADDR && S_AXI_WSTRB[0])
        begin
            next_wdt_rate = S_AXI_WDATA[2:0];
            next_wdt_win = S_AXI_WDATA[WDT_WIN_BIT];
            next_wdt_cnt = '0;
            next_wdt_armed = 1'b0;
        end
        if (svc_wr && wdt_rate != 3'h0)
        begin
            if (S_AXI_WDATA[7:0] == SVC_KEY_ARM)
                next_wdt_armed = 1'b1;
            else if (S_AXI_WDATA[7:0] == SVC_KEY_FIRE && wdt_armed)
            begin
                next_wdt_armed = 1'b0;
                next_wdt_cnt = '0;
            end
        end
        // Hardware set wins over software clear
        if (wr_fire && S_AXI_AWADDR == STATUS_ADDR && S_AXI_WSTRB[0])
        begin
            if (S_AXI_WDATA[STAT_PIF_BIT])
                next_pif = 1'b0;
            if (S_AXI_WDATA[STAT_SELF_CLOCK_INTERRUPT_FLAG_BIT])
                next_self_clock_interrupt_flag = 1'b0;
        end
        if (pit_tick)
            next_pif = 1'b1;
        if (scm_entry)
        begin
            next_scm = 1'b1;
            next_self_clock_interrupt_flag = 1'b1;
            next_qc_start = 1'b1;
            next_ctrl.pll_clock_select = 1'b0;
        end
        if (scm_exit)
            next_scm = 1'b0;
        // Standby entry sequence and wake
        unique case (sb)
            SB_RUN:
                if (STANDBY_REQ)
                    next_sb = SB_PLL_DESEL;
            SB_PLL_DESEL:
            begin
                if (ctrl.standby_pll_off)
                    next_ctrl.pll_clock_select = 1'b0;
                next_sb = SB_PLL_OFF;
            end
            SB_PLL_OFF: next_sb = SB_CORE_OFF;
            SB_CORE_OFF: next_sb = SB_SYS_OFF;
            SB_SYS_OFF: next_sb = SB_ACTIVE;
            SB_ACTIVE: ;
        endcase
        // Select is left cleared on wake; software sets it again
        if (sb != SB_RUN && wake)
            next_sb = SB_RUN;
        if (any_reset)
        begin
            next_ctrl = CTRL_RESET;
            next_ctrl.self_clock_enable = CTRL_RESET.self_clock_enable
                || cm_reset;
            next_pit_rate = RATE_RESET;
            next_wdt_rate = RATE_RESET;
            next_wdt_win = WIN_RESET;
            next_wdt_armed = 1'b0;
            next_wdt_cnt = '0;
            next_pit_cnt = '0;
            next_pif = 1'b0;
            next_sb = SB_RUN;
            next_sys_reset = 1'b1;
            next_cause = cm_reset ? CAUSE_CLOCK_MONITOR : CAUSE_WATCHDOG;
        end
    end

    // External reset restores every setting at once
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl <= CTRL_RESET;
            pit_rate <= RATE_RESET;
            wdt_rate <= RATE_RESET;
            wdt_win <= WIN_RESET;
            wdt_armed <= 1'b0;
            wdt_cnt <= '0;
            pit_cnt <= '0;
            pif <= 1'b0;
            self_clock_interrupt_flag <= 1'b0;
            self_clock_mode <= 1'b0;
            sys_reset <= 1'b0;
            qc_start <= 1'b0;
            cause <= CAUSE_NONE;
            sb <= SB_RUN;
        end
        else
        begin
            ctrl <= next_ctrl;
            pit_rate <= next_pit_rate;
            wdt_rate <= next_wdt_rate;
            wdt_win <= next_wdt_win;
            wdt_armed <= next_wdt_armed;
            wdt_cnt <= next_wdt_cnt;
            pit_cnt <= next_pit_cnt;
            pif <= next_pif;
            self_clock_interrupt_flag <= next_self_clock_interrupt_flag;
            self_clock_mode <= next_scm;
            sys_reset <= next_sys_reset;
            qc_start <= next_qc_start;
            cause <= next_cause;
            sb <= next_sb;
        end
    end

    // Clock gating controls
    always_comb
    begin
        next_pll_en = self_clock_mode
            || !(ctrl.standby_pll_off
                 && (sb == SB_CORE_OFF || sb == SB_SYS_OFF
                     || sb == SB_ACTIVE));
        next_core_en = !((ctrl.standby_core_clock_off
                          || ctrl.standby_system_clock_off)
                         && (sb == SB_SYS_OFF || sb == SB_ACTIVE));
        next_sys_en = !(ctrl.standby_system_clock_off
                        && sb == SB_ACTIVE);
        next_osc_red = ctrl.standby_reduced_osc_amplitude
            && sb == SB_ACTIVE;
        next_voltage_regulator_en = self_clock_mode || !PSEUDO_STOP;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pll_en <= 1'b1;
            core_en <= 1'b1;
            sys_en <= 1'b1;
            osc_red <= 1'b0;
            voltage_regulator_en <= 1'b1;
        end
        else
        begin
            pll_en <= next_pll_en;
            core_en <= next_core_en;
            sys_en <= next_sys_en;
            osc_red <= next_osc_red;
            voltage_regulator_en <= next_voltage_regulator_en;
        end
    end

    assign SYS_RESET = sys_reset;
    assign RESET_CAUSE = cause;
    assign SELF_CLOCK_MODE = self_clock_mode;
    assign PLL_SELECT = ctrl.pll_clock_select;
    assign PLL_ENABLE = pll_en;
    assign VOLTAGE_REGULATOR_ENABLE = voltage_regulator_en;
    assign QC_START = qc_start;
    assign CORE_CLK_EN = core_en;
    assign SYS_CLK_EN = sys_en;
    assign OSC_REDUCED = osc_red;
    assign STANDBY_ACK = (sb == SB_ACTIVE);

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);

    chk_bad_key_reset: assert property (
        key_bad |=> SYS_RESET && RESET_CAUSE == CAUSE_WATCHDOG)
        else $error("bad service key did not reset");
    chk_wdt_timeout: assert property (
        wdt_timeout |=> SYS_RESET && wdt_cnt == '0)
        else $error("watchdog timeout did not reset");
    chk_window_early: assert property (
        early |=> SYS_RESET ##1 !SYS_RESET)
        else $error("early windowed service did not reset");
    chk_pit_flag_set: assert property (
        pit_tick && !any_reset |=> pif && (pit_cnt == '0 || pit_cnt == 1))
        else $error("periodic end did not set flag");
    chk_pit_restart: assert property (
        wr_fire && S_AXI_AWADDR == PIT_CTRL_ADDR |=> pit_cnt == '0)
        else $error("periodic control write did not restart");
    chk_rate_zero_stop: assert property (
        pit_rate == 3'h0 && $past(pit_rate) == 3'h0 |-> $stable(pit_cnt))
        else $error("zero rate periodic timer counted");
    chk_cm_reset_self_clock_enable: assert property (
        cm_reset |=> ctrl.self_clock_enable
            && RESET_CAUSE == CAUSE_CLOCK_MONITOR)
        else $error("clock monitor reset left self clock off");
    chk_scm_entry: assert property (
        scm_entry && !any_reset |=> SELF_CLOCK_MODE && !PLL_SELECT
            && QC_START)
        else $error("self clock entry incomplete");
    chk_scm_exit: assert property (
        scm_exit && !scm_entry |=> !SELF_CLOCK_MODE)
        else $error("self clock not left on good oscillator");
    chk_scm_keeps_pll: assert property (
        self_clock_mode [*2] |-> PLL_ENABLE && VOLTAGE_REGULATOR_ENABLE)
        else $error("PLL or regulator off in self clock");
    chk_standby_order: assert property (
        sb == SB_PLL_DESEL && ctrl.standby_pll_off && !wake && !any_reset
        |=> !PLL_SELECT ##2 !PLL_ENABLE || SELF_CLOCK_MODE || sb == SB_RUN)
        else $error("standby entry order broken");

    cov_pit_tick: cover property (pit_tick);
    cov_scm_entry: cover property (scm_entry);
    cov_standby: cover property (sb == SB_ACTIVE ##[1:50] sb == SB_RUN);
    cov_service: cover property (svc_wr && wdt_armed && !early);

endmodule // crm_top

// [rtl/crm_pkg.sv]
// Constants and types shared by the clock reset mode control block
package crm_pkg;

    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] PIT_CTRL_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] WDT_CTRL_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] WDT_SVC_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h10;

    // Status register field positions
    localparam int STAT_PIF_BIT = 0;
    localparam int STAT_SELF_CLOCK_INTERRUPT_FLAG_BIT = 1;
    localparam int STAT_SCM_BIT = 2;
    localparam int STAT_STANDBY_BIT = 3;
    localparam int STAT_CAUSE_LSB = 4;
    // Watchdog control field positions
    localparam int WDT_WIN_BIT = 7;

    // Watchdog service keys
    localparam logic [7:0] SVC_KEY_ARM = 8'h55;
    localparam logic [7:0] SVC_KEY_FIRE = 8'hAA;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timer period exponents: period = 2**(rate + base) core cycles
    localparam int WDT_BASE_EXP = 10;
    localparam int PIT_BASE_EXP = 8;
    localparam int CNT_W = 24;

    typedef struct packed {
        logic standby_reduced_osc_amplitude;
        logic standby_watchdog_off;
        logic standby_periodic_timer_off;
        logic standby_system_clock_off;
        logic standby_core_clock_off;
        logic standby_pll_off;
        logic periodic_pseudo_stop_enable;
        logic watchdog_pseudo_stop_enable;
        logic periodic_interrupt_enable;
        logic pll_clock_select;
        logic self_clock_interrupt_enable;
        logic self_clock_enable;
        logic clock_monitor_enable;
    } crm_ctrl_type;

    localparam crm_ctrl_type CTRL_RESET = 13'h0003;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic WIN_RESET = 1'b0;

    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_WATCHDOG = 2'h1,
        CAUSE_CLOCK_MONITOR = 2'h2
    } crm_cause_type;

    typedef enum logic [5:0] {
        SB_RUN = 6'h01,
        SB_PLL_DESEL = 6'h02,
        SB_PLL_OFF = 6'h04,
        SB_CORE_OFF = 6'h08,
        SB_SYS_OFF = 6'h10,
        SB_ACTIVE = 6'h20
    } crm_sb_type;

endpackage

// [testbench/crm_core_model.sv]
// Core-side partner: standby request and wake source
`timescale 1ns/1ps
module crm_core_model (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Reset
    input wire logic sleep, // Bench asks for standby
    input wire logic wake, // Other wake source
    input wire logic irq, // Interrupts from block
    output logic standby_req, // Standby request
    output logic core_wake // Wake interrupt
);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            {standby_req, core_wake} <= 2'h0;
        else
        begin
            core_wake <= wake;
            standby_req <= sleep & !(irq | wake);
        end
endmodule // crm_core_model

// [testbench/crm_top_tb_top.sv]
// Bench for the clock reset mode control block
`timescale 1ns/1ps
module crm_top_tb_top
    import crm_pkg::*;
;
    logic CORE_CLK, ARST_N, awv, wv, br, arv, rr, slp, wk, ofail, ook;
    logic awrdy, bv, arrdy, rv, srst, pirq, sirq, self_clock_mode, psel, pen, cen;
    logic ack, sreq, cwk, sen, ored, pstp;
    logic [ADDR_W-1:0] aw, ar;
    logic [31:0] wd, rdata, rd_d;
    logic [1:0] rresp, rd_r;
    logic [7:0] ev;
    int n_fail = 0;
    int num_checks = 0;
    int n_rst = 0;
    int k;
    assign ev = {self_clock_mode, ack, pirq, srst, rv, arrdy, bv, awrdy};
    crm_top #(.WDT_BASE(4), .PIT_BASE(2)) DUT (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .S_AXI_AWADDR(aw),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
        .STANDBY_REQ(sreq), .CORE_WAKE(cwk), .PSEUDO_STOP(pstp),
        .OSC_FAIL(ofail), .OSC_OK(ook), .SYS_RESET(srst), .RESET_CAUSE(),
        .PIT_IRQ(pirq), .SCM_IRQ(sirq), .SELF_CLOCK_MODE(self_clock_mode),
        .PLL_SELECT(psel), .PLL_ENABLE(pen), .VOLTAGE_REGULATOR_ENABLE(), .QC_START(),
        .CORE_CLK_EN(cen), .SYS_CLK_EN(sen), .OSC_REDUCED(ored),
        .STANDBY_ACK(ack)
    );
    crm_core_model core (
        .clk(CORE_CLK), .rst_n(ARST_N), .sleep(slp), .wake(wk),
        .irq(pirq | sirq), .standby_req(sreq), .core_wake(cwk)
    );
    initial
    begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) if (srst === 1'b1) n_rst++;
    task automatic final_report;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // Bounded wait on one watched output
    task automatic hold(input int b, input logic v);
        for (int i = 0; i < 300 && ev[b] !== v; i++) @(negedge CORE_CLK);
        if (ev[b] !== v)
        begin
            n_fail++;
            $display("CHECK FAILED %0t wait %0d", $time, b);
            final_report;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        {aw, wd, awv, wv, br} <= {a, d, 3'h7};
        hold(0, 1'b1);
        @(posedge CORE_CLK);
        {awv, wv} <= 2'h0;
        hold(1, 1'b1);
        @(posedge CORE_CLK);
        br <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CORE_CLK);
        {ar, arv, rr} <= {a, 2'h3};
        hold(2, 1'b1);
        @(posedge CORE_CLK);
        arv <= 1'b0;
        hold(3, 1'b1);
        @(posedge CORE_CLK);
        {rd_d, rd_r} = {rdata, rresp};
        rr <= 1'b0;
    endtask
    initial
    begin
        {ARST_N, awv, wv, br, arv, rr, slp, wk, ofail, aw, ar, wd} = 0;
        ook = 1'b1;
        pstp = 1'b0;
        repeat (5) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        rd(CTRL_ADDR);
        chk(rd_d, 32'h3);
        rd(8'h14);
        chk(32'(rd_r), 32'(RESP_SLVERR));
        pstp <= 1'b1;
        wr(PIT_CTRL_ADDR, 32'h1);
        wr(CTRL_ADDR, 32'h13);
        repeat (20) @(posedge CORE_CLK);
        chk(32'(pirq), 32'h0);
        wr(CTRL_ADDR, 32'h53);
        hold(5, 1'b1);
        rd(STATUS_ADDR);
        chk(32'(rd_d[STAT_PIF_BIT]), 32'h1);
        pstp <= 1'b0;
        wr(PIT_CTRL_ADDR, 32'h0);
        wr(STATUS_ADDR, 32'h1);
        repeat (40) @(posedge CORE_CLK);
        chk(32'(pirq), 32'h0);
        wr(CTRL_ADDR, 32'h138B);
        slp <= 1'b1;
        hold(6, 1'b1);
        // Gating outputs follow the state by one cycle
        repeat (2) @(negedge CORE_CLK);
        chk({psel, pen, cen, sen, ored}, 32'h1);
        @(posedge CORE_CLK);
        {slp, wk} <= 2'h1;
        hold(6, 1'b0);
        @(posedge CORE_CLK) wk <= 1'b0;
        chk(32'(psel), 32'h0);
        wr(CTRL_ADDR, 32'h0B);
        chk(32'(psel), 32'h1);
        ARST_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        chk(32'(psel), 32'h0);
        rd(CTRL_ADDR);
        chk(rd_d, 32'h3);
        wr(CTRL_ADDR, 32'h0B);
        {ook, ofail} <= 2'h1;
        hold(7, 1'b1);
        chk(32'(psel), 32'h0);
        @(posedge CORE_CLK) {ook, ofail} <= 2'h2;
        hold(7, 1'b0);
        wr(CTRL_ADDR, 32'h1);
        {ook, ofail} <= 2'h1;
        hold(4, 1'b1);
        rd(STATUS_ADDR);
        chk(32'(rd_d[5:4]), 32'h2);
        rd(CTRL_ADDR);
        chk(32'(rd_d[1]), 32'h1);
        {ook, ofail} <= 2'h2;
        // Reset pulse is over before the write returns; count it instead
        k = n_rst;
        wr(WDT_SVC_ADDR, 32'h12);
        @(posedge CORE_CLK);
        chk(n_rst, k + 1);
        rd(STATUS_ADDR);
        chk(32'(rd_d[5:4]), 32'h1);
        wr(WDT_CTRL_ADDR, 32'h81);
        k = n_rst;
        wr(WDT_SVC_ADDR, 32'h55);
        @(posedge CORE_CLK);
        chk(n_rst, k + 1);
        wr(WDT_CTRL_ADDR, 32'h81);
        k = n_rst;
        // Service lands at count 25 and 28 of 32, inside the last quarter
        repeat (23) @(posedge CORE_CLK);
        wr(WDT_SVC_ADDR, 32'h55);
        wr(WDT_SVC_ADDR, 32'hAA);
        @(posedge CORE_CLK);
        chk(n_rst, k);
        wr(WDT_CTRL_ADDR, 32'h1);
        k = n_rst;
        repeat (4)
        begin
            wr(WDT_SVC_ADDR, 32'h55);
            wr(WDT_SVC_ADDR, 32'hAA);
        end
        chk(n_rst, k);
        hold(4, 1'b1);
        final_report;
    end
endmodule // crm_top_tb_top
